// ### design/potc_pkg.sv
// Package with register map, reset values and field layout of the pattern output trigger control.
package potc_pkg;
   localparam logic [31:0] POTC_OFS_ENABLE = 32'h0000_0000;
   localparam logic [31:0] POTC_OFS_TRIGSEL = 32'h0000_0004;
   localparam logic [31:0] POTC_OFS_MODE = 32'h0000_0008;
   localparam logic [31:0] POTC_OFS_STAGED = 32'h0000_000C;
   localparam logic [31:0] POTC_OFS_LATCH = 32'h0000_0010;
   localparam logic [7:0] POTC_RST_ENABLE = 8'h00;
   localparam logic [7:0] POTC_RST_TRIGSEL = 8'hFF;
   localparam logic [7:0] POTC_RST_MODE = 8'hF0;
   localparam logic [7:0] POTC_RST_STAGED = 8'h00;
   localparam logic [7:0] POTC_RST_LATCH = 8'h00;
   localparam logic [7:0] POTC_MODE_RSVD = 8'hF0;
   localparam int POTC_SEL_G3_LSB = 6;
   localparam int POTC_SEL_G2_LSB = 4;
   localparam int POTC_SEL_G1_LSB = 2;
   localparam int POTC_SEL_G0_LSB = 0;
   localparam int POTC_NCH = 4;
   localparam logic [1:0] POTC_HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] POTC_HSIZE_WORD = 3'h2;
   typedef enum logic [2:0]
   {
      POTC_BUS_IDLE = 3'b001,
      POTC_BUS_WRITE = 3'b010,
      POTC_BUS_READ = 3'b100
   } potc_bus_e;
endpackage : potc_pkg

// ### design/potc_trig_route.sv
// Routes one selected timer channel's compare match pulses to one output group.
`timescale 1ns/1ps
module potc_trig_route
   import potc_pkg::*;
(
   input wire logic [1:0] sel, // Channel select field.
   input wire logic [potc_pkg::POTC_NCH-1:0] match_a, // Compare match A pulses.
   input wire logic [potc_pkg::POTC_NCH-1:0] match_b, // Compare match B pulses.
   output logic trig_a, // Selected match A.
   output logic trig_b // Selected match B.
);
   // The field value is the channel number directly.
   assign trig_a = match_a[sel];
   assign trig_b = match_b[sel];
endmodule : potc_trig_route

// ### design/potc_group_xfer.sv
// Computes the next latch nibble of one output group from its trigger, mode and enables.
`timescale 1ns/1ps
module potc_group_xfer
   import potc_pkg::*;
(
   input wire logic nonoverlap, // Group mode bit.
   input wire logic trig_a, // Selected compare match A.
   input wire logic trig_b, // Selected compare match B.
   input wire logic [3:0] enable, // Per-bit transfer enables.
   input wire logic [3:0] staged, // Staged next data.
   input wire logic [3:0] latch, // Current latch nibble.
   output logic [3:0] latch_d // Next latch nibble.
);
   logic [3:0] take;
   always_comb
   begin
      take = 4'h0;
      if (trig_a)
      begin
         take = enable;
      end
      else if (trig_b && nonoverlap)
      begin
         take = enable & ~staged;
      end
      latch_d = (latch & ~take) | (staged & take);
   end
endmodule : potc_group_xfer

// ### design/potc_top.sv
// Pattern output trigger control for outputs 15 to 8 with an AHB-Lite register slave.
//
// Our own choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
// Notes on behaviour
// - Trigger copies enabled staged bits into latch.
// - Disabled bits never change on trigger.
// - Enable register resets to zero, kept.
// - Trigger select resets to all ones.
// - Bits 7:6 pick channel for group 3.
// - Bits 5:4 pick channel for group 2.
// - Bits 3:2 pick channel for group 1.
// - Bits 1:0 pick channel for group 0.
// - Field value equals channel number.
// - Mode register resets to F0.
// - Mode bits 7:4 always read one.
// - Mode bits 3:0 select group modes; only bits 3:2 drive a group here.
// - Ordinary mode updates on match A only.
// - Non-overlap uses matches A and B.
// - Non-overlap match A transfers all enabled.
// - Non-overlap match B transfers only zeros.
// - Staging register holds groups 3, 2 data.
module potc_top
   import potc_pkg::*;
(
   input wire logic core_clk, // System clock.
   input wire logic rst, // Asynchronous reset, active high.
   input wire logic hsel, // Slave select.
   input wire logic [31:0] haddr, // Byte address.
   input wire logic [1:0] htrans, // Transfer type.
   input wire logic hwrite, // Write when high.
   input wire logic [2:0] hsize, // Transfer size.
   input wire logic [31:0] hwdata, // Write data.
   input wire logic hready, // Bus ready.
   output logic [31:0] hrdata, // Read data.
   output logic hreadyout, // Slave ready.
   output logic hresp, // Always OKAY.
   input wire logic [potc_pkg::POTC_NCH-1:0] match_a, // Compare match A pulses.
   input wire logic [potc_pkg::POTC_NCH-1:0] match_b, // Compare match B pulses.
   output logic [7:0] pattern_pins_upper, // Port data latch bits 15 to 8.
   output logic [3:0] group_trig_a, // Selected match A per group.
   output logic [3:0] group_trig_b // Selected match B per group.
);
   import potc_pkg::*;

   logic [7:0] enable_q;
   logic [7:0] trigsel_q;
   logic [3:0] mode_q;
   logic [7:0] staged_q;
   logic [7:0] latch_q;
   logic [7:0] latch_d;
   potc_bus_e bus_q;
   logic [31:0] addr_q;
   logic [31:0] rdata_d;
   logic take_req;

   function automatic logic [1:0] sel_field(input logic [7:0] r, input int lsb);
      sel_field = r[lsb +: 2];
   endfunction : sel_field

   // One-hot channel mask of a select field, kept apart from the routing mux.
   function automatic logic [POTC_NCH-1:0] chan_onehot(input logic [1:0] s);
      case (s)
         2'h0: chan_onehot = 4'h1;
         2'h1: chan_onehot = 4'h2;
         2'h2: chan_onehot = 4'h4;
         default: chan_onehot = 4'h8;
      endcase
   endfunction : chan_onehot

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign take_req = hsel && hready && (htrans == POTC_HTRANS_NONSEQ);

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         bus_q <= POTC_BUS_IDLE;
         addr_q <= 32'h0000_0000;
      end
      else if (hready)
      begin
         addr_q <= haddr;
         if (take_req && hwrite)
         begin
            bus_q <= POTC_BUS_WRITE;
         end
         else if (take_req)
         begin
            bus_q <= POTC_BUS_READ;
         end
         else
         begin
            bus_q <= POTC_BUS_IDLE;
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         enable_q <= POTC_RST_ENABLE;
         trigsel_q <= POTC_RST_TRIGSEL;
         mode_q <= POTC_RST_MODE[3:0];
         staged_q <= POTC_RST_STAGED;
      end
      else if (bus_q == POTC_BUS_WRITE)
      begin
         if (addr_q == POTC_OFS_ENABLE)
         begin
            enable_q <= hwdata[7:0];
         end
         else if (addr_q == POTC_OFS_TRIGSEL)
         begin
            trigsel_q <= hwdata[7:0];
         end
         else if (addr_q == POTC_OFS_MODE)
         begin
            mode_q <= hwdata[3:0];
         end
         else if (addr_q == POTC_OFS_STAGED)
         begin
            staged_q <= hwdata[7:0];
         end
      end
   end

   always_comb
   begin
      rdata_d = 32'h0000_0000;
      if (addr_q == POTC_OFS_ENABLE)
      begin
         rdata_d[7:0] = enable_q;
      end
      else if (addr_q == POTC_OFS_TRIGSEL)
      begin
         rdata_d[7:0] = trigsel_q;
      end
      else if (addr_q == POTC_OFS_MODE)
      begin
         rdata_d[7:0] = POTC_MODE_RSVD | {4'h0, mode_q};
      end
      else if (addr_q == POTC_OFS_STAGED)
      begin
         rdata_d[7:0] = staged_q;
      end
      else if (addr_q == POTC_OFS_LATCH)
      begin
         rdata_d[7:0] = latch_q;
      end
   end
   assign hrdata = (bus_q == POTC_BUS_READ) ? rdata_d : 32'h0000_0000;

   // Groups 1 and 0 are only routed out; their data path lives elsewhere.
   potc_trig_route u_route3 (.sel(sel_field(trigsel_q, POTC_SEL_G3_LSB)),
      .match_a(match_a), .match_b(match_b),
      .trig_a(group_trig_a[3]), .trig_b(group_trig_b[3]));
   potc_trig_route u_route2 (.sel(sel_field(trigsel_q, POTC_SEL_G2_LSB)),
      .match_a(match_a), .match_b(match_b),
      .trig_a(group_trig_a[2]), .trig_b(group_trig_b[2]));
   potc_trig_route u_route1 (.sel(sel_field(trigsel_q, POTC_SEL_G1_LSB)),
      .match_a(match_a), .match_b(match_b),
      .trig_a(group_trig_a[1]), .trig_b(group_trig_b[1]));
   potc_trig_route u_route0 (.sel(sel_field(trigsel_q, POTC_SEL_G0_LSB)),
      .match_a(match_a), .match_b(match_b),
      .trig_a(group_trig_a[0]), .trig_b(group_trig_b[0]));

   potc_group_xfer u_xfer3 (.nonoverlap(mode_q[3]), .trig_a(group_trig_a[3]),
      .trig_b(group_trig_b[3]), .enable(enable_q[7:4]), .staged(staged_q[7:4]),
      .latch(latch_q[7:4]), .latch_d(latch_d[7:4]));
   potc_group_xfer u_xfer2 (.nonoverlap(mode_q[2]), .trig_a(group_trig_a[2]),
      .trig_b(group_trig_b[2]), .enable(enable_q[3:0]), .staged(staged_q[3:0]),
      .latch(latch_q[3:0]), .latch_d(latch_d[3:0]));

   // The latch is also writable so software can preset the idle level.
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         latch_q <= POTC_RST_LATCH;
      end
      else if (bus_q == POTC_BUS_WRITE && addr_q == POTC_OFS_LATCH)
      begin
         latch_q <= hwdata[7:0];
      end
      else
      begin
         latch_q <= latch_d;
      end
   end
   assign pattern_pins_upper = latch_q;

   // Software write to the port latch; it overrides any trigger in that cycle.
   logic latch_wr;
   assign latch_wr = (bus_q == POTC_BUS_WRITE) && (addr_q == POTC_OFS_LATCH);

   a_disabled_hold: assert property (@(posedge core_clk) disable iff (rst)
      !(bus_q == POTC_BUS_WRITE && addr_q == POTC_OFS_LATCH)
      |=> ((latch_q ^ $past(latch_q)) & ~$past(enable_q)) == 8'h00)
      else $error("Disabled output bit changed.");
   a_g3_ordinary_copy: assert property (@(posedge core_clk) disable iff (rst)
      (group_trig_a[3] && !(bus_q == POTC_BUS_WRITE && addr_q == POTC_OFS_LATCH))
      |=> (latch_q[7:4] & $past(enable_q[7:4])) == ($past(staged_q[7:4]) & $past(enable_q[7:4])))
      else $error("Group 3 match A did not copy staged bits.");
   a_g2_nov_zero_only: assert property (@(posedge core_clk) disable iff (rst)
      (mode_q[2] && group_trig_b[2] && !group_trig_a[2]
       && !(bus_q == POTC_BUS_WRITE && addr_q == POTC_OFS_LATCH))
      |=> (latch_q[3:0] & ~$past(latch_q[3:0])) == 4'h0)
      else $error("Group 2 match B raised an output.");
   a_g3_ordinary_b: assert property (@(posedge core_clk) disable iff (rst)
      (!mode_q[3] && !group_trig_a[3] && !(bus_q == POTC_BUS_WRITE && addr_q == POTC_OFS_LATCH))
      |=> $stable(latch_q[7:4]))
      else $error("Group 3 changed without match A in ordinary mode.");
   a_route_g3: assert property (@(posedge core_clk) disable iff (rst)
      group_trig_a[3] == match_a[trigsel_q[7:6]])
      else $error("Group 3 routing wrong.");
   a_route_g2: assert property (@(posedge core_clk) disable iff (rst)
      group_trig_b[2] == match_b[trigsel_q[5:4]])
      else $error("Group 2 routing wrong.");
   a_route_g1: assert property (@(posedge core_clk) disable iff (rst)
      group_trig_a[1] == match_a[trigsel_q[3:2]])
      else $error("Group 1 routing wrong.");
   a_route_g0: assert property (@(posedge core_clk) disable iff (rst)
      group_trig_a[0] == match_a[trigsel_q[1:0]])
      else $error("Group 0 routing wrong.");
   a_mode_rsvd_ones: assert property (@(posedge core_clk) disable iff (rst)
      (bus_q == POTC_BUS_READ && addr_q == POTC_OFS_MODE) |-> hrdata[7:4] == 4'hF)
      else $error("Mode reserved bits not read as one.");

   // Register writes land one edge after the data phase and nothing else moves them.
   a_enable_write: assert property (@(posedge core_clk) disable iff (rst)
      (bus_q == POTC_BUS_WRITE && addr_q == POTC_OFS_ENABLE)
      |=> enable_q == $past(hwdata[7:0]))
      else $error("Enable register write lost.");
   a_enable_kept: assert property (@(posedge core_clk) disable iff (rst)
      !(bus_q == POTC_BUS_WRITE && addr_q == POTC_OFS_ENABLE)
      |=> $stable(enable_q))
      else $error("Enable register changed without a write.");
   a_trigsel_write: assert property (@(posedge core_clk) disable iff (rst)
      (bus_q == POTC_BUS_WRITE && addr_q == POTC_OFS_TRIGSEL)
      |=> trigsel_q == $past(hwdata[7:0]))
      else $error("Trigger select write lost.");
   a_trigsel_kept: assert property (@(posedge core_clk) disable iff (rst)
      !(bus_q == POTC_BUS_WRITE && addr_q == POTC_OFS_TRIGSEL)
      |=> $stable(trigsel_q))
      else $error("Trigger select changed without a write.");
   a_mode_write: assert property (@(posedge core_clk) disable iff (rst)
      (bus_q == POTC_BUS_WRITE && addr_q == POTC_OFS_MODE)
      |=> mode_q == $past(hwdata[3:0]))
      else $error("Mode register write lost.");
   a_mode_kept: assert property (@(posedge core_clk) disable iff (rst)
      !(bus_q == POTC_BUS_WRITE && addr_q == POTC_OFS_MODE)
      |=> $stable(mode_q))
      else $error("Mode register changed without a write.");
   a_staged_write: assert property (@(posedge core_clk) disable iff (rst)
      (bus_q == POTC_BUS_WRITE && addr_q == POTC_OFS_STAGED)
      |=> staged_q == $past(hwdata[7:0]))
      else $error("Staged data write lost.");
   a_staged_kept: assert property (@(posedge core_clk) disable iff (rst)
      !(bus_q == POTC_BUS_WRITE && addr_q == POTC_OFS_STAGED)
      |=> $stable(staged_q))
      else $error("Staged data changed without a write.");

   // Read data stands in the data phase only and carries the addressed register.
   a_enable_read: assert property (@(posedge core_clk) disable iff (rst)
      (bus_q == POTC_BUS_READ && addr_q == POTC_OFS_ENABLE)
      |-> hrdata == {24'h00_0000, enable_q})
      else $error("Enable register read wrong.");
   a_trigsel_read: assert property (@(posedge core_clk) disable iff (rst)
      (bus_q == POTC_BUS_READ && addr_q == POTC_OFS_TRIGSEL)
      |-> hrdata == {24'h00_0000, trigsel_q})
      else $error("Trigger select read wrong.");
   a_mode_read_low: assert property (@(posedge core_clk) disable iff (rst)
      (bus_q == POTC_BUS_READ && addr_q == POTC_OFS_MODE)
      |-> hrdata[3:0] == mode_q)
      else $error("Mode group bits read wrong.");
   a_staged_read: assert property (@(posedge core_clk) disable iff (rst)
      (bus_q == POTC_BUS_READ && addr_q == POTC_OFS_STAGED)
      |-> hrdata == {24'h00_0000, staged_q})
      else $error("Staged data read wrong.");

   // Transfers into the latch, per group and per mode.
   a_g2_match_a_copy: assert property (@(posedge core_clk) disable iff (rst)
      (group_trig_a[2] && !latch_wr)
      |=> ((latch_q[3:0] ^ $past(staged_q[3:0])) & $past(enable_q[3:0])) == 4'h0)
      else $error("Group 2 match A did not copy staged bits.");
   a_g3_nov_zero_only: assert property (@(posedge core_clk) disable iff (rst)
      (mode_q[3] && group_trig_b[3] && !group_trig_a[3] && !latch_wr)
      |=> (latch_q[7:4] & ~$past(latch_q[7:4])) == 4'h0)
      else $error("Group 3 match B raised an output.");
   a_g2_ordinary_b: assert property (@(posedge core_clk) disable iff (rst)
      (!mode_q[2] && !group_trig_a[2] && !latch_wr) |=> $stable(latch_q[3:0]))
      else $error("Group 2 changed without match A in ordinary mode.");
   a_g3_nov_b_zeros: assert property (@(posedge core_clk) disable iff (rst)
      (mode_q[3] && group_trig_b[3] && !group_trig_a[3] && !latch_wr)
      |=> (latch_q[7:4] & $past(enable_q[7:4]) & ~$past(staged_q[7:4])) == 4'h0)
      else $error("Group 3 match B did not clear staged zeros.");
   a_g2_nov_b_zeros: assert property (@(posedge core_clk) disable iff (rst)
      (mode_q[2] && group_trig_b[2] && !group_trig_a[2] && !latch_wr)
      |=> (latch_q[3:0] & $past(enable_q[3:0]) & ~$past(staged_q[3:0])) == 4'h0)
      else $error("Group 2 match B did not clear staged zeros.");
   a_g3_idle_hold: assert property (@(posedge core_clk) disable iff (rst)
      (!group_trig_a[3] && !group_trig_b[3] && !latch_wr) |=> $stable(latch_q[7:4]))
      else $error("Group 3 changed with no trigger.");
   a_g2_idle_hold: assert property (@(posedge core_clk) disable iff (rst)
      (!group_trig_a[2] && !group_trig_b[2] && !latch_wr) |=> $stable(latch_q[3:0]))
      else $error("Group 2 changed with no trigger.");

   // Routing checked against a one-hot decode of each select field.
   a_route_g3_b: assert property (@(posedge core_clk) disable iff (rst)
      group_trig_b[3] == |(match_b & chan_onehot(sel_field(trigsel_q, POTC_SEL_G3_LSB))))
      else $error("Group 3 match B routing wrong.");
   a_route_g3_a: assert property (@(posedge core_clk) disable iff (rst)
      group_trig_a[3] == |(match_a & chan_onehot(sel_field(trigsel_q, POTC_SEL_G3_LSB))))
      else $error("Group 3 match A decode wrong.");
   a_route_g2_a: assert property (@(posedge core_clk) disable iff (rst)
      group_trig_a[2] == |(match_a & chan_onehot(sel_field(trigsel_q, POTC_SEL_G2_LSB))))
      else $error("Group 2 match A routing wrong.");
   a_route_g1_b: assert property (@(posedge core_clk) disable iff (rst)
      group_trig_b[1] == |(match_b & chan_onehot(sel_field(trigsel_q, POTC_SEL_G1_LSB))))
      else $error("Group 1 match B routing wrong.");
   a_route_g1_a: assert property (@(posedge core_clk) disable iff (rst)
      group_trig_a[1] == |(match_a & chan_onehot(sel_field(trigsel_q, POTC_SEL_G1_LSB))))
      else $error("Group 1 match A decode wrong.");
   a_route_g0_b: assert property (@(posedge core_clk) disable iff (rst)
      group_trig_b[0] == |(match_b & chan_onehot(sel_field(trigsel_q, POTC_SEL_G0_LSB))))
      else $error("Group 0 match B routing wrong.");
endmodule : potc_top

// ### bench/potc_timer_model.sv
// Timer unit model that issues one-cycle compare match pulses on request.
`timescale 1ns/1ps
module potc_timer_model
   import potc_pkg::*;
(
   input wire logic core_clk, // System clock.
   input wire logic rst, // Asynchronous reset, active high.
   input wire logic req, // Fire request.
   input wire logic [1:0] ch, // Channel to fire.
   input wire logic [1:0] ab, // Bit 1 fires match A, bit 0 match B.
   output logic [potc_pkg::POTC_NCH-1:0] match_a, // Compare match A pulses.
   output logic [potc_pkg::POTC_NCH-1:0] match_b // Compare match B pulses.
);
   // Each pulse lasts as many cycles as req is held high; the bench holds req for one cycle.
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         match_a <= '0;
         match_b <= '0;
      end
      else
      begin
         match_a <= (req && ab[1]) ? POTC_NCH'(1 << ch) : '0;
         match_b <= (req && ab[0]) ? POTC_NCH'(1 << ch) : '0;
      end
   end
endmodule : potc_timer_model

// ### bench/potc_top_tb.sv
// Self-checking testbench of the pattern output trigger control.
`timescale 1ns/1ps
module potc_top_tb;
   import potc_pkg::*;
   logic core_clk = 0;
   logic rst = 1;
   logic hsel = 0;
   logic [31:0] haddr = '0;
   logic [1:0] htrans = '0;
   logic hwrite = 0;
   logic [2:0] hsize = POTC_HSIZE_WORD;
   logic [31:0] hwdata = '0;
   logic [31:0] hrdata, rd;
   logic hreadyout, hresp, req = 0;
   logic [1:0] ch = '0, ab = '0;
   logic [3:0] match_a, match_b, trig_a, trig_b;
   logic [7:0] pins, en, sel, mode, stg, lat;
   logic [31:0] lfsr = 32'h3FC66423;
   int err_count = 0, compares = 0;
   always #12.5 core_clk = ~core_clk;
   potc_timer_model TMR (.core_clk, .rst, .req, .ch, .ab, .match_a, .match_b);
   potc_top DUT (.core_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .match_a, .match_b,
      .pattern_pins_upper(pins), .group_trig_a(trig_a), .group_trig_b(trig_b));
   function automatic logic [31:0] next_rand(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : next_rand
   function automatic logic [7:0] exp_pins(input logic [7:0] e, s, md, st, la,
      input logic [1:0] c, m);
      logic [7:0] r;
      logic ha, hb;
      r = la;
      for (int g = 0; g < 2; g++)
      begin
         ha = m[1] && s[4 + 2 * g +: 2] == c;
         hb = m[0] && s[4 + 2 * g +: 2] == c && md[2 + g];
         for (int i = 4 * g; i < 4 * g + 4; i++)
            if (e[i] && (ha || (hb && !st[i])))
               r[i] = st[i];
      end
      return r;
   endfunction : exp_pins
   function automatic logic [7:0] exp_trig(input logic [7:0] s, input logic [1:0] c, m);
      logic [7:0] r;
      r = 8'h00;
      for (int g = 0; g < 4; g++)
      begin
         r[4 + g] = m[1] && s[2 * g +: 2] == c;
         r[g] = m[0] && s[2 * g +: 2] == c;
      end
      return r;
   endfunction : exp_trig
   task automatic chk_trg(input logic [7:0] got, exp);
      compares++;
      if (got !== exp)
      begin
         err_count++;
         $display("[ERR] %0t group triggers %h expected %h", $time, got, exp);
      end
   endtask : chk_trg
   task automatic chk_reg(input logic [31:0] got, exp);
      compares++;
      if (got !== exp)
      begin
         err_count++;
         $display("[ERR] %0t register read %h expected %h", $time, got, exp);
      end
   endtask : chk_reg
   task automatic chk_pin(input logic [7:0] got, exp);
      compares++;
      if (got !== exp)
      begin
         err_count++;
         $display("[ERR] %0t pattern pins %h expected %h", $time, got, exp);
      end
   endtask : chk_pin
   task automatic bus(input logic w, input logic [31:0] a, d);
      hsel <= 1;
      haddr <= a;
      htrans <= POTC_HTRANS_NONSEQ;
      hwrite <= w;
      @(posedge core_clk);
      while (hreadyout !== 1'b1)
         @(posedge core_clk);
      hsel <= 0;
      htrans <= '0;
      hwdata <= d;
      @(posedge core_clk);
      while (hreadyout !== 1'b1)
         @(posedge core_clk);
      rd = hrdata;
   endtask : bus
   task automatic rdchk(input logic [31:0] a, e);
      bus(1'b0, a, '0);
      chk_reg(rd, e);
   endtask : rdchk
   task automatic do_reset;
      rst <= 1;
      repeat (8) @(posedge core_clk);
      rst <= 0;
      @(posedge core_clk);
      rdchk(POTC_OFS_ENABLE, 32'h0000_0000);
      rdchk(POTC_OFS_TRIGSEL, 32'h0000_00FF);
      rdchk(POTC_OFS_MODE, 32'h0000_00F0);
      rdchk(POTC_OFS_STAGED, 32'h0000_0000);
      rdchk(32'h0000_0020, 32'h0000_0000);
      chk_pin(pins, 8'h00);
   endtask : do_reset
   task automatic end_sim;
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_sim
   initial
   begin
      do_reset();
      for (int n = 0; n < 60; n++)
      begin
         lfsr = next_rand(lfsr);
         {en, sel, stg, lat} = lfsr;
         lfsr = next_rand(lfsr);
         mode = {4'hF, lfsr[3:0]};
         if (n == 0)
            {en, sel, mode} = 24'hFFFFF0;
         bus(1'b1, POTC_OFS_ENABLE, {24'h0, en});
         bus(1'b1, POTC_OFS_TRIGSEL, {24'h0, sel});
         bus(1'b1, POTC_OFS_MODE, {24'h0, mode});
         bus(1'b1, POTC_OFS_STAGED, {24'h0, stg});
         bus(1'b1, POTC_OFS_LATCH, {24'h0, lat});
         rdchk(POTC_OFS_ENABLE, {24'h0, en});
         rdchk(POTC_OFS_TRIGSEL, {24'h0, sel});
         rdchk(POTC_OFS_MODE, {24'h0, mode});
         rdchk(POTC_OFS_STAGED, {24'h0, stg});
         chk_pin(pins, lat);
         req <= 1;
         ch <= (n == 0) ? 2'h3 : lfsr[5:4];
         ab <= (n == 0) ? 2'h2 : lfsr[7:6];
         @(posedge core_clk);
         req <= 0;
         @(negedge core_clk);
         chk_trg({trig_a, trig_b}, exp_trig(sel, ch, ab));
         repeat (2) @(posedge core_clk);
         chk_pin(pins, exp_pins(en, sel, mode, stg, lat, ch, ab));
      end
      do_reset();
      end_sim();
   end
   initial
   begin
      repeat (20000) @(posedge core_clk);
      err_count++;
      end_sim();
   end
endmodule : potc_top_tb
